// [logic/olr_pkg.sv]
// constants for the one-line-mode routing block: register map, fields, formats
// assumes an 8-bit register port and 24-bit parallel converter words
package olr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 24;
    // register offsets, byte addressed on the plain port, and the reset value of the registers
    localparam logic [7:0] REG_FUNC_ADDR = 8'h03;
    localparam logic [7:0] REG_FMT_ADDR = 8'h04;
    localparam logic [7:0] REG_MISC_ADDR = 8'h05;
    localparam logic [7:0] REG_STAT_ADDR = 8'h06;
    localparam logic [7:0] REG_RESET = 8'h00;
    // functional mode fields
    localparam int FUNC_CODEC_FM_LSB = 6;
    localparam int FUNC_AI_FM_LSB = 4;
    localparam int FUNC_PSEL_LSB = 0;
    // interface format fields
    localparam int FMT_DIF_LSB = 6;
    localparam int FMT_ADC_OL_LSB = 4;
    localparam int FMT_DAC_OL_LSB = 2;
    // misc control bits
    localparam int MISC_CODEC_MS_BIT = 7;
    localparam int MISC_AI_MS_BIT = 6;
    localparam int MISC_EXT_CLK_BIT = 5;
    // status bits
    localparam int STAT_EXT_SEEN_BIT = 0;
    localparam int STAT_OLM_BIT = 1;
    // field encodings
    localparam logic [1:0] PSEL_CODEC = 2'h0;
    localparam logic [1:0] PSEL_AI = 2'h2;
    localparam logic [1:0] DIF_LJ = 2'h0;
    localparam logic [1:0] DIF_I2S = 2'h1;
    localparam logic [1:0] DIF_RJ = 2'h2;
    localparam logic [1:0] OL_NONE = 2'h0;
    localparam logic [1:0] OL_1 = 2'h1;
    localparam logic [1:0] OL_2 = 2'h2;
    localparam logic [1:0] SPEED_SINGLE = 2'h0;
    localparam logic [1:0] SPEED_DOUBLE = 2'h1;
    localparam logic [1:0] SPEED_QUAD = 2'h2;
    // slot geometry, in bit clocks, and playback input masks
    localparam logic [6:0] STD_W = 7'h18;
    localparam logic [6:0] OLM1_W = 7'h14;
    localparam logic [6:0] OLM2_W = 7'h18;
    localparam logic [6:0] RJ_OFFSET = 7'h08;
    localparam logic [4:0] EXT_BITS = 5'h18;
    localparam logic [3:0] IN_USED_OLM = 4'h9;
    localparam logic [3:0] IN_USED_STD = 4'hF;
endpackage

// [logic/olr_framer.sv]
// serialiser for one audio output line: two-channel formats or six-slot one-line
// assumes bit clock edges arrive as one-cycle pulses already synchronised
`timescale 1ns/1ps
`default_nettype none
module olr_framer
    import olr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic bclk_fall,
    input wire logic fclk,
    input wire logic enable,
    input wire logic [1:0] line_mode,
    input wire logic [1:0] dif,
    input wire logic [23:0] ch0,
    input wire logic [23:0] ch1,
    input wire logic [23:0] ch2,
    input wire logic [23:0] ch3,
    input wire logic [23:0] ch4,
    input wire logic [23:0] ch5,
    output logic sdo
);
    logic [6:0] bitcnt_r;
    logic [6:0] bitcnt_nxt;
    logic fclk_prev_r;
    logic fclk_prev_nxt;
    logic sdo_r;
    logic sdo_nxt;

    function automatic logic [23:0] chan(input logic [2:0] idx);
        case (idx)
            3'h0: chan = ch0;
            3'h1: chan = ch1;
            3'h2: chan = ch2;
            3'h3: chan = ch3;
            3'h4: chan = ch4;
            3'h5: chan = ch5;
            default: chan = 24'h000000;
        endcase
    endfunction

    // bit of the half frame at position cnt; half is the frame clock level
    function automatic logic pick_bit(input logic [6:0] cnt, input logic half);
        logic [6:0] pos;
        logic [6:0] w;
        logic [6:0] off;
        logic [1:0] k;
        logic left;
        logic ok;
        logic single_line_operation;
        logic [23:0] word;
        pos = cnt;
        left = half;
        ok = 1'b1;
        single_line_operation = (line_mode != OL_NONE);
        w = (line_mode == OL_1) ? OLM1_W : OLM2_W;
        if (!single_line_operation)
        begin
            w = STD_W;
            // format field only matters outside one-line operation
            if (dif == DIF_I2S)
            begin
                left = ~half;
                ok = (cnt != 7'h00);
                pos = cnt - 7'h01;
            end
            else if (dif == DIF_RJ)
            begin
                ok = (cnt >= RJ_OFFSET);
                pos = cnt - RJ_OFFSET;
            end
        end
        k = 2'h0;
        off = pos;
        if (pos >= w)
        begin
            k = 2'h1;
            off = pos - w;
        end
        if (pos >= (w + w))
        begin
            k = 2'h2;
            off = pos - w - w;
        end
        if (off >= w || (!single_line_operation && k != 2'h0) || pos >= (w + w + w))
            ok = 1'b0;
        // lefts travel in even slots, rights in odd ones
        word = chan({k, ~left});
        pick_bit = ok ? word[5'd23 - off[4:0]] : 1'b0;
    endfunction

    // new bit launched on the falling bit clock, valid for the rising one
    always_comb
    begin
        bitcnt_nxt = bitcnt_r;
        fclk_prev_nxt = fclk_prev_r;
        sdo_nxt = sdo_r;
        if (bclk_fall)
        begin
            fclk_prev_nxt = fclk;
            if (fclk != fclk_prev_r)
                bitcnt_nxt = 7'h00;
            else if (bitcnt_r != 7'h7F)
                bitcnt_nxt = bitcnt_r + 7'h01;
            sdo_nxt = enable ? pick_bit(bitcnt_nxt, fclk) : 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bitcnt_r <= 7'h00;
            fclk_prev_r <= 1'b0;
            sdo_r <= 1'b0;
        end
        else if (ce)
        begin
            bitcnt_r <= bitcnt_nxt;
            fclk_prev_r <= fclk_prev_nxt;
            sdo_r <= sdo_nxt;
        end
    end

    assign sdo = sdo_r;
endmodule // olr_framer
`default_nettype wire

// [logic/olr_one_line_route.sv]
// one-line-mode routing: external converter capture, stream merge, port select
// assumes port clocks and external data lines are asynchronous pins
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module olr_one_line_route
    import olr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic CODEC_BIT_CLOCK,
    input wire logic CODEC_FRAME_CLOCK,
    input wire logic AUDIO_INTERFACE_BIT_CLOCK,
    input wire logic AUDIO_INTERFACE_FRAME_CLOCK,
    input wire logic EXTERNAL_ADC_INPUT_A,
    input wire logic EXTERNAL_ADC_INPUT_B,
    input wire logic [23:0] INT_ADC_LEFT,
    input wire logic [23:0] INT_ADC_RIGHT,
    input wire logic [23:0] SPDIF_LEFT,
    input wire logic [23:0] SPDIF_RIGHT,
    output logic CODEC_PORT_DATA_OUT,
    output logic AUDIO_INTERFACE_DATA_OUT,
    output logic CODEC_PORT_MASTER_SELECT,
    output logic AUDIO_INTERFACE_MASTER_SELECT,
    output logic [1:0] CODEC_SPEED_MODE,
    output logic [1:0] AUDIO_INTERFACE_SPEED_MODE,
    output logic [3:0] CODEC_INPUT_USED
);
    // speed group of a speed-mode field; the unused code reads as quad
    function automatic logic [1:0] speed_of(input logic [1:0] fm);
        case (fm)
            SPEED_SINGLE: speed_of = SPEED_SINGLE;
            SPEED_DOUBLE: speed_of = SPEED_DOUBLE;
            default: speed_of = SPEED_QUAD;
        endcase
    endfunction

    // registers
    logic [7:0] func_r;
    logic [7:0] func_nxt;
    logic [7:0] fmt_r;
    logic [7:0] fmt_nxt;
    logic [7:0] misc_r;
    logic [7:0] misc_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    // pin synchronisers: bits 0 codec bclk, 1 codec fclk, 2 ai bclk, 3 ai fclk, 4 A, 5 B
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_s3_r;
    // external converter capture
    logic ext_fclk_prev_r;
    logic ext_fclk_prev_nxt;
    logic [4:0] ext_cnt_r;
    logic [4:0] ext_cnt_nxt;
    logic [23:0] sh_a_r;
    logic [23:0] sh_a_nxt;
    logic [23:0] sh_b_r;
    logic [23:0] sh_b_nxt;
    logic [23:0] ext_a_l_r;
    logic [23:0] ext_a_l_nxt;
    logic [23:0] ext_a_r_r;
    logic [23:0] ext_a_r_nxt;
    logic [23:0] ext_b_l_r;
    logic [23:0] ext_b_l_nxt;
    logic [23:0] ext_b_r_r;
    logic [23:0] ext_b_r_nxt;
    logic ext_seen_r;
    logic ext_seen_nxt;

    logic [1:0] psel;
    logic [1:0] dif;
    logic [1:0] adc_ol;
    logic [1:0] dac_ol;
    logic ext_from_codec;
    logic olm_active;
    logic codec_rise;
    logic codec_fall;
    logic ai_rise;
    logic ai_fall;
    logic ext_rise;
    logic ext_fclk;
    logic to_ai;
    logic [23:0] m2;
    logic [23:0] m3;
    logic [23:0] m4;
    logic [23:0] m5;
    logic [23:0] ai0;
    logic [23:0] ai1;
    logic [1:0] ai_mode;

    // field extraction
    assign psel = func_r[FUNC_PSEL_LSB +: 2];
    assign dif = fmt_r[FMT_DIF_LSB +: 2];
    assign adc_ol = fmt_r[FMT_ADC_OL_LSB +: 2];
    assign dac_ol = fmt_r[FMT_DAC_OL_LSB +: 2];
    assign ext_from_codec = misc_r[MISC_EXT_CLK_BIT];
    assign olm_active = (adc_ol != OL_NONE);
    // codes 01 and 11 are not legal; they fall back to the codec route
    assign to_ai = (psel == PSEL_AI);

    // edges from the second and third stages only, never the first
    assign codec_rise = pin_s2_r[0] & ~pin_s3_r[0];
    assign codec_fall = ~pin_s2_r[0] & pin_s3_r[0];
    assign ai_rise = pin_s2_r[2] & ~pin_s3_r[2];
    assign ai_fall = ~pin_s2_r[2] & pin_s3_r[2];
    // software must match this bit to the board wiring
    assign ext_rise = ext_from_codec ? codec_rise : ai_rise;
    assign ext_fclk = ext_from_codec ? pin_s2_r[1] : pin_s2_r[3];

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_s3_r <= 6'h00;
        end
        else if (CE)
        begin
            pin_s1_r <= {EXTERNAL_ADC_INPUT_B, EXTERNAL_ADC_INPUT_A,
                         AUDIO_INTERFACE_FRAME_CLOCK, AUDIO_INTERFACE_BIT_CLOCK,
                         CODEC_FRAME_CLOCK, CODEC_BIT_CLOCK};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // register port: writes land at once, reads answer one cycle later
    always_comb
    begin
        func_nxt = func_r;
        fmt_nxt = fmt_r;
        misc_nxt = misc_r;
        rdata_nxt = 8'h00;
        if (REG_WR)
        begin
            case (REG_ADDR)
                REG_FUNC_ADDR: func_nxt = REG_WDATA;
                REG_FMT_ADDR: fmt_nxt = REG_WDATA;
                REG_MISC_ADDR: misc_nxt = REG_WDATA;
                default: ;
            endcase
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                REG_FUNC_ADDR: rdata_nxt = func_r;
                REG_FMT_ADDR: rdata_nxt = fmt_r;
                REG_MISC_ADDR: rdata_nxt = misc_r;
                REG_STAT_ADDR:
                begin
                    rdata_nxt[STAT_EXT_SEEN_BIT] = ext_seen_r;
                    rdata_nxt[STAT_OLM_BIT] = olm_active;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            func_r <= REG_RESET;
            fmt_r <= REG_RESET;
            misc_r <= REG_RESET;
            rdata_r <= 8'h00;
        end
        else if (CE)
        begin
            func_r <= func_nxt;
            fmt_r <= fmt_nxt;
            misc_r <= misc_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // external capture: fixed left-justified 24-bit, MSB on first rise after frame edge
    // no format field is consulted here, so port settings cannot disturb it
    always_comb
    begin
        ext_fclk_prev_nxt = ext_fclk_prev_r;
        ext_cnt_nxt = ext_cnt_r;
        sh_a_nxt = sh_a_r;
        sh_b_nxt = sh_b_r;
        ext_a_l_nxt = ext_a_l_r;
        ext_a_r_nxt = ext_a_r_r;
        ext_b_l_nxt = ext_b_l_r;
        ext_b_r_nxt = ext_b_r_r;
        ext_seen_nxt = ext_seen_r;
        if (ext_rise)
        begin
            ext_fclk_prev_nxt = ext_fclk;
            sh_a_nxt = {sh_a_r[22:0], pin_s2_r[4]};
            sh_b_nxt = {sh_b_r[22:0], pin_s2_r[5]};
            // bits past the 24th (64 or 128 Fs padding) are ignored
            if (ext_fclk != ext_fclk_prev_r)
                ext_cnt_nxt = 5'h01;
            else if (ext_cnt_r < EXT_BITS)
                ext_cnt_nxt = ext_cnt_r + 5'h01;
            if (ext_cnt_nxt == EXT_BITS && ext_cnt_r != EXT_BITS)
            begin
                ext_seen_nxt = 1'b1;
                if (ext_fclk)
                begin
                    ext_a_l_nxt = sh_a_nxt;
                    ext_b_l_nxt = sh_b_nxt;
                end
                else
                begin
                    ext_a_r_nxt = sh_a_nxt;
                    ext_b_r_nxt = sh_b_nxt;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            ext_fclk_prev_r <= 1'b0;
            ext_cnt_r <= 5'h00;
            sh_a_r <= 24'h000000;
            sh_b_r <= 24'h000000;
            ext_a_l_r <= 24'h000000;
            ext_a_r_r <= 24'h000000;
            ext_b_l_r <= 24'h000000;
            ext_b_r_r <= 24'h000000;
            ext_seen_r <= 1'b0;
        end
        else if (CE)
        begin
            ext_fclk_prev_r <= ext_fclk_prev_nxt;
            ext_cnt_r <= ext_cnt_nxt;
            sh_a_r <= sh_a_nxt;
            sh_b_r <= sh_b_nxt;
            ext_a_l_r <= ext_a_l_nxt;
            ext_a_r_r <= ext_a_r_nxt;
            ext_b_l_r <= ext_b_l_nxt;
            ext_b_r_r <= ext_b_r_nxt;
            ext_seen_r <= ext_seen_nxt;
        end
    end

    // external channels join the stream only in one-line operation
    assign m2 = olm_active ? ext_a_l_r : 24'h000000;
    assign m3 = olm_active ? ext_a_r_r : 24'h000000;
    assign m4 = olm_active ? ext_b_l_r : 24'h000000;
    assign m5 = olm_active ? ext_b_r_r : 24'h000000;

    // audio port carries converters when selected, otherwise the S/PDIF pair
    assign ai0 = to_ai ? INT_ADC_LEFT : SPDIF_LEFT;
    assign ai1 = to_ai ? INT_ADC_RIGHT : SPDIF_RIGHT;
    assign ai_mode = to_ai ? adc_ol : OL_NONE;

    olr_framer u_codec_framer (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CE),
        .bclk_fall(codec_fall),
        .fclk(pin_s2_r[1]),
        .enable(~to_ai),
        .line_mode(adc_ol),
        .dif(dif),
        .ch0(INT_ADC_LEFT),
        .ch1(INT_ADC_RIGHT),
        .ch2(m2),
        .ch3(m3),
        .ch4(m4),
        .ch5(m5),
        .sdo(CODEC_PORT_DATA_OUT)
    );

    olr_framer u_ai_framer (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CE),
        .bclk_fall(ai_fall),
        .fclk(pin_s2_r[3]),
        .enable(1'b1),
        .line_mode(ai_mode),
        .dif(dif),
        .ch0(ai0),
        .ch1(ai1),
        .ch2(to_ai ? m2 : 24'h000000),
        .ch3(to_ai ? m3 : 24'h000000),
        .ch4(to_ai ? m4 : 24'h000000),
        .ch5(to_ai ? m5 : 24'h000000),
        .sdo(AUDIO_INTERFACE_DATA_OUT)
    );

    // configuration seen by the rest of the codec
    assign REG_RDATA = rdata_r;
    assign CODEC_PORT_MASTER_SELECT = misc_r[MISC_CODEC_MS_BIT];
    assign AUDIO_INTERFACE_MASTER_SELECT = misc_r[MISC_AI_MS_BIT];
    assign CODEC_SPEED_MODE = speed_of(func_r[FUNC_CODEC_FM_LSB +: 2]);
    assign AUDIO_INTERFACE_SPEED_MODE = speed_of(func_r[FUNC_AI_FM_LSB +: 2]);
    // one-line playback uses only the first and fourth data inputs
    assign CODEC_INPUT_USED = (dac_ol != OL_NONE) ? IN_USED_OLM : IN_USED_STD;
endmodule // olr_one_line_route
`default_nettype wire

// [sim/olr_route_props.sv]
// checker for the one-line routing block: register port and serial output timing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module olr_route_props
    import olr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic CODEC_BIT_CLOCK,
    input wire logic AUDIO_INTERFACE_BIT_CLOCK,
    input wire logic CODEC_PORT_DATA_OUT,
    input wire logic AUDIO_INTERFACE_DATA_OUT,
    input wire logic CODEC_PORT_MASTER_SELECT,
    input wire logic AUDIO_INTERFACE_MASTER_SELECT,
    input wire logic [1:0] CODEC_SPEED_MODE,
    input wire logic [1:0] AUDIO_INTERFACE_SPEED_MODE,
    input wire logic [3:0] CODEC_INPUT_USED
);
    logic [7:0] func_r, func_nxt, fmt_r, fmt_nxt, misc_r, misc_nxt;
    logic [6:0] age_r, age_nxt;
    logic [5:0] cf_r, cf_nxt, af_r, af_nxt;
    logic cb_r, ab_r, wr_hit;
    // code 3 is read as quad speed
    function automatic logic [1:0] spd(input logic [1:0] c);
        return (c == 2'h3) ? 2'h2 : c;
    endfunction
    assign wr_hit = REG_WR && CE;
    // shadow registers, cycles since last write, recent bit-clock falls
    always_comb
    begin
        func_nxt = (wr_hit && REG_ADDR == REG_FUNC_ADDR) ? REG_WDATA : func_r;
        fmt_nxt = (wr_hit && REG_ADDR == REG_FMT_ADDR) ? REG_WDATA : fmt_r;
        misc_nxt = (wr_hit && REG_ADDR == REG_MISC_ADDR) ? REG_WDATA : misc_r;
        age_nxt = wr_hit ? 7'h00 : ((age_r == 7'h64) ? age_r : age_r + 7'h01);
        cf_nxt = {cf_r[4:0], cb_r & ~CODEC_BIT_CLOCK};
        af_nxt = {af_r[4:0], ab_r & ~AUDIO_INTERFACE_BIT_CLOCK};
    end
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            {func_r, fmt_r, misc_r, age_r} <= '0;
            {cf_r, af_r, cb_r, ab_r} <= '0;
        end
        else
        begin
            {func_r, fmt_r, misc_r, age_r} <= {func_nxt, fmt_nxt, misc_nxt, age_nxt};
            {cf_r, af_r} <= {cf_nxt, af_nxt};
            {cb_r, ab_r} <= {CODEC_BIT_CLOCK, AUDIO_INTERFACE_BIT_CLOCK};
        end
    end
    default clocking dcb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside the read answer cycle");
    a_write_readback: assert property ((REG_WR && REG_ADDR == REG_MISC_ADDR)
        ##1 (REG_RD && REG_ADDR == REG_MISC_ADDR) |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("back to back read does not return written value");
    a_unmapped_zero: assert property (REG_RD && (REG_ADDR < REG_FUNC_ADDR
        || REG_ADDR > REG_STAT_ADDR) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_master_mirror: assert property (age_r > 7'h02 |->
        CODEC_PORT_MASTER_SELECT == misc_r[MISC_CODEC_MS_BIT]
        && AUDIO_INTERFACE_MASTER_SELECT == misc_r[MISC_AI_MS_BIT])
        else $error("master select outputs differ from register");
    a_speed_decode: assert property (age_r > 7'h02 |->
        CODEC_SPEED_MODE == spd(func_r[FUNC_CODEC_FM_LSB +: 2])
        && AUDIO_INTERFACE_SPEED_MODE == spd(func_r[FUNC_AI_FM_LSB +: 2]))
        else $error("speed mode outputs differ from register");
    a_inputs_used: assert property (age_r > 7'h02 |-> CODEC_INPUT_USED ==
        ((fmt_r[FMT_DAC_OL_LSB +: 2] != OL_NONE) ? IN_USED_OLM : IN_USED_STD))
        else $error("playback input mask wrong");
    a_codec_quiet: assert property (age_r > 7'h14
        && func_r[FUNC_PSEL_LSB +: 2] == PSEL_AI |-> !CODEC_PORT_DATA_OUT)
        else $error("codec output active while audio port selected");
    a_codec_stands: assert property (age_r > 7'h14
        && $changed(CODEC_PORT_DATA_OUT) |-> |cf_r[5:1])
        else $error("codec output changed away from a bit clock fall");
    a_audio_stands: assert property (age_r > 7'h14
        && $changed(AUDIO_INTERFACE_DATA_OUT) |-> |af_r[5:1])
        else $error("audio output changed away from a bit clock fall");
endmodule // olr_route_props
bind olr_one_line_route olr_route_props u_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CODEC_BIT_CLOCK(CODEC_BIT_CLOCK),
    .AUDIO_INTERFACE_BIT_CLOCK(AUDIO_INTERFACE_BIT_CLOCK),
    .CODEC_PORT_DATA_OUT(CODEC_PORT_DATA_OUT), .AUDIO_INTERFACE_DATA_OUT(AUDIO_INTERFACE_DATA_OUT),
    .CODEC_PORT_MASTER_SELECT(CODEC_PORT_MASTER_SELECT),
    .AUDIO_INTERFACE_MASTER_SELECT(AUDIO_INTERFACE_MASTER_SELECT),
    .CODEC_SPEED_MODE(CODEC_SPEED_MODE), .AUDIO_INTERFACE_SPEED_MODE(AUDIO_INTERFACE_SPEED_MODE),
    .CODEC_INPUT_USED(CODEC_INPUT_USED));
`default_nettype wire

// [sim/olr_host_model.sv]
// far side: host clocks for both ports and two external stereo converters
// assumes both ports share one bit clock and one frame clock
`timescale 1ns/1ps
`default_nettype none
module olr_host_model
(
    input wire logic run,
    input wire logic [7:0] half,
    input wire logic [23:0] a_l,
    input wire logic [23:0] a_r,
    input wire logic [23:0] b_l,
    input wire logic [23:0] b_r,
    output logic bclk,
    output logic fclk,
    output logic sd_a,
    output logic sd_b
);
    int cnt;
    // bit clock stands low outside frames; odd phase keeps edges off the core clock
    initial
    begin
        {bclk, fclk, sd_a, sd_b} = 4'h0;
        cnt = 0;
        #3;
        forever
        begin
            if (!run)
            begin
                {bclk, sd_a, sd_b} = 3'h0;
                #4;
            end
            else
            begin
                #32 bclk = 1'b1;
                #32 bclk = 1'b0;
                cnt = cnt + 1;
                // one frame clock for both ports, so both rates stay equal
                if (cnt >= half)
                begin
                    cnt = 0;
                    fclk = ~fclk;
                end
                // left-justified 24-bit words; pulled low past the word
                sd_a = (cnt < 24) ? (fclk ? a_l[23 - cnt] : a_r[23 - cnt]) : 1'b0;
                sd_b = (cnt < 24) ? (fclk ? b_l[23 - cnt] : b_r[23 - cnt]) : 1'b0;
            end
        end
    end
endmodule // olr_host_model
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the one-line routing block
// assumes the host model clocks both ports; clock enable is dropped low for one register write only
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import olr_pkg::*;
    localparam logic [23:0] IL = 24'hA5C3F1;
    localparam logic [23:0] IR = 24'h3C5A96;
    localparam logic [23:0] SL = 24'h9F0E1D;
    localparam logic [23:0] SR = 24'h61B2C4;
    localparam logic [23:0] AL = 24'hC0FFEE;
    localparam logic [23:0] AR = 24'h5A0F3C;
    localparam logic [23:0] BL = 24'hD1E2F3;
    localparam logic [23:0] BR = 24'h2468AC;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic chk_q = 1'b0;
    logic chk_d = 1'b0;
    logic run = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] exp_q = 8'h00;
    logic [7:0] exp_d = 8'h00;
    logic [7:0] half = 8'h20;
    logic [7:0] rdata;
    logic bclk, fclk, sd_a, sd_b, cdo, ado, cms, ams;
    logic [1:0] csp, asp;
    logic [3:0] used;
    logic [63:0] cw, aw;
    int n_errors = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    olr_one_line_route dut (.CORE_CLK(clk), .SYS_RST(rst), .CE(ce), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .CODEC_BIT_CLOCK(bclk), .CODEC_FRAME_CLOCK(fclk), .AUDIO_INTERFACE_BIT_CLOCK(bclk),
        .AUDIO_INTERFACE_FRAME_CLOCK(fclk), .EXTERNAL_ADC_INPUT_A(sd_a),
        .EXTERNAL_ADC_INPUT_B(sd_b), .INT_ADC_LEFT(IL), .INT_ADC_RIGHT(IR),
        .SPDIF_LEFT(SL), .SPDIF_RIGHT(SR), .CODEC_PORT_DATA_OUT(cdo),
        .AUDIO_INTERFACE_DATA_OUT(ado), .CODEC_PORT_MASTER_SELECT(cms),
        .AUDIO_INTERFACE_MASTER_SELECT(ams), .CODEC_SPEED_MODE(csp),
        .AUDIO_INTERFACE_SPEED_MODE(asp), .CODEC_INPUT_USED(used));
    olr_host_model host (.run(run), .half(half), .a_l(AL), .a_r(AR), .b_l(BL), .b_r(BR),
        .bclk(bclk), .fclk(fclk), .sd_a(sd_a), .sd_b(sd_b));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle per call, so calls run back to back
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        exp_q <= d;
        chk_q <= r;
        @(posedge clk);
    endtask
    // read data is looked at only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (chk_d)
            check(64'(rdata), 64'(exp_d));
        chk_d <= chk_q;
        exp_d <= exp_q;
    end
    // shifts both outputs at rising bit clock from the chosen frame edge
    task automatic cap(input int nb, input int skip, input logic hi);
        cw = '0;
        aw = '0;
        if (hi)
            @(posedge fclk);
        else
            @(negedge fclk);
        repeat (skip) @(posedge bclk);
        repeat (nb)
        begin
            @(posedge bclk);
            #1;
            cw = {cw[62:0], cdo};
            aw = {aw[62:0], ado};
        end
        @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog well beyond the expected run of about 80 us
    initial
    begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place at 07
        for (int a = 3; a < 8; a++)
            bus(1'b0, 1'b1, a[7:0], 8'h00);
        bus(1'b1, 1'b0, REG_MISC_ADDR, 8'hE0);
        bus(1'b0, 1'b1, REG_MISC_ADDR, 8'hE0);
        bus(1'b1, 1'b0, REG_FUNC_ADDR, 8'hF3);
        bus(1'b0, 1'b1, REG_FUNC_ADDR, 8'hF3);
        bus(1'b1, 1'b0, 8'h07, 8'h55);
        bus(1'b1, 1'b0, REG_STAT_ADDR, 8'hFF);
        bus(1'b0, 1'b1, 8'h07, 8'h00);
        bus(1'b0, 1'b1, REG_STAT_ADDR, 8'h00);
        repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
        // writes refused while frozen
        ce <= 1'b0;
        bus(1'b1, 1'b0, REG_FUNC_ADDR, 8'h00);
        ce <= 1'b1;
        bus(1'b0, 1'b1, REG_FUNC_ADDR, 8'hF3);
        check(64'({cms, ams}), 64'h3);
        check(64'({csp, asp}), 64'({SPEED_QUAD, SPEED_QUAD}));
        check(64'(used), 64'(IN_USED_STD));
        $display("test registers done");
        // configuration 1 outside one-line: every standard format, external converters running but kept out of the stream
        bus(1'b1, 1'b0, REG_FUNC_ADDR, 8'h00);
        bus(1'b1, 1'b0, REG_MISC_ADDR, 8'hC0);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        run <= 1'b1;
        for (int f = 0; f < 3; f++)
        begin
            bus(1'b1, 1'b0, REG_FMT_ADDR, 8'(f << FMT_DIF_LSB));
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            cap((f == 0) ? 32 : 24, (f == 2) ? 8 : f, f != 1);
            check(cw, (f == 0) ? {32'h0, IL, 8'h00} : {40'h0, IL});
            check(aw, (f == 0) ? {32'h0, SL, 8'h00} : {40'h0, SL});
        end
        $display("test standard formats done");
        // configuration 1, one-line mode 1 both ways, format field set to I2S
        half <= 8'h40;
        bus(1'b1, 1'b0, REG_FMT_ADDR, 8'h54);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(posedge fclk);
        cap(60, 0, 1'b1);
        check(cw, {4'h0, IL[23:4], AL[23:4], BL[23:4]});
        check(64'(used), 64'(IN_USED_OLM));
        $display("test configuration 1 done");
        // configuration 2: stream on the audio port, converters on codec clocks
        bus(1'b1, 1'b0, REG_MISC_ADDR, 8'hE0);
        bus(1'b1, 1'b0, REG_FUNC_ADDR, 8'h02);
        bus(1'b1, 1'b0, REG_FMT_ADDR, 8'h10);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(posedge fclk);
        cap(60, 0, 1'b0);
        check(aw, {4'h0, IR[23:4], AR[23:4], BR[23:4]});
        check(cw, 64'h0);
        check(64'(used), 64'(IN_USED_STD));
        // one-line mode 2 at 256 Fs
        bus(1'b1, 1'b0, REG_FMT_ADDR, 8'h20);
        half <= 8'h80;
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        cap(48, 0, 1'b1);
        check(aw, {16'h0, IL, AL});
        bus(1'b0, 1'b1, REG_STAT_ADDR, 8'h03);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        run <= 1'b0;
        $display("test configuration 2 done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
